// file: hw/ssg_fixed_select.sv
// Fixed setpoint table with direct and binary selection
`timescale 1ns/100ps
module ssg_fixed_select (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_we,
    input wire logic [3:0] i_widx,
    input wire logic [15:0] i_wdata,
    input wire logic [3:0] i_ridx,
    output logic [15:0] o_rdata,
    input wire logic [3:0] i_sel,
    input wire logic i_direct,
    output ssg_pkg::ssg_speed_type o_setpoint
);
    import ssg_pkg::*;

    ssg_speed_type table_q [16];
    logic signed [17:0] sum;

    // Table entries, one write port from the bus
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            for (int i = 0; i < 16; i++) begin
                table_q[i] <= 16'sh0000;
            end
        end else if (i_we) begin
            table_q[i_widx] <= i_wdata;
        end
    end

    assign o_rdata = table_q[i_ridx];

    // sum of chosen setpoints, saturated so it never wraps
    always_comb begin
        sum = 18'sh00000;
        for (int i = 0; i < 4; i++) begin
            if (i_sel[i]) begin
                sum = sum + 18'(table_q[i]);
            end
        end
    end

    // mode one picks direct, else binary
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_setpoint <= 16'sh0000;
        end else if (i_direct) begin
            if (sum > 18'sh07fff) begin
                o_setpoint <= 16'sh7fff;
            end else if (sum < -18'sh08000) begin
                o_setpoint <= 16'sh8000;
            end else begin
                o_setpoint <= sum[15:0];
            end
        end else begin
            // one entry indexed by the four bits
            o_setpoint <= table_q[i_sel];
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);

    property p_direct_none;
        i_direct && i_sel == 4'h0 |=> o_setpoint == 16'sh0000;
    endproperty
    a_direct_none: assert property (p_direct_none) else $error("direct none not zero");

    property p_binary_pick;
        !i_direct && !i_we |=> o_setpoint == table_q[$past(i_sel)];
    endproperty
    a_binary_pick: assert property (p_binary_pick) else $error("binary pick wrong");
endmodule

// file: hw/ssg_pkg.sv
// Constants and types shared by the speed setpoint source generator
package ssg_pkg;
    typedef logic signed [15:0] ssg_speed_type;
    typedef enum logic [1:0] {RAMP_IDLE, RAMP_UP, RAMP_DOWN} ssg_ramp_state_type;

    // Register byte offsets
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_UP_TIME = 8'h04;
    localparam logic [7:0] OFS_DOWN_TIME = 8'h08;
    localparam logic [7:0] OFS_START = 8'h0c;
    localparam logic [7:0] OFS_MAX = 8'h10;
    localparam logic [7:0] OFS_MIN = 8'h14;
    localparam logic [7:0] OFS_REF_SPEED = 8'h18;
    localparam logic [7:0] OFS_FIX_MODE = 8'h1c;
    localparam logic [7:0] OFS_EMU_SRC = 8'h20;
    localparam logic [7:0] OFS_FIX_SRC = 8'h24;
    localparam logic [7:0] OFS_MAIN_SRC = 8'h28;
    localparam logic [7:0] OFS_ADD_SRC = 8'h2c;
    localparam logic [7:0] OFS_SET_SRC = 8'h30;
    localparam logic [7:0] OFS_STATUS = 8'h34;
    localparam logic [1:0] FIX_PAGE = 2'h1;

    // Configuration word fields
    localparam int CFG_RETAIN = 0;
    localparam int CFG_AUTO_RAMP = 1;
    localparam int CFG_ROUND = 2;
    localparam int CFG_NV = 3;
    localparam int CFG_ALWAYS = 4;
    localparam logic [4:0] CONFIG_RST = 5'h06;

    // Reset values
    localparam int RAMP_TIME_S = 10;
    localparam logic [15:0] RAMP_TIME_RST = 16'(RAMP_TIME_S * 1000);
    localparam logic [15:0] SPEED_RST = 16'h0000;
    localparam logic [15:0] REF_SPEED_RST = 16'h05dc;
    localparam logic [15:0] FIX_MODE_RST = 16'h0001;
    localparam logic [15:0] FIX_MODE_DIRECT = 16'h0001;
    localparam logic [31:0] SRC_RST = 32'h0000_0000;

    // Setpoint source codes
    localparam logic [15:0] SRC_EMU = 16'h041a;
    localparam logic [15:0] SRC_FIXED = 16'h0400;

    // Binary source codes
    localparam logic [7:0] BSRC_ONE = 8'h01;
    localparam logic [3:0] BSRC_DI = 4'h1;
    localparam logic [3:0] BSRC_FB = 4'h2;

    // Timing: ramp times count in milliseconds
    localparam int CLK_PERIOD_NS = 50;
    localparam int MS_NS = 1000000;
    localparam logic [31:0] CYC_PER_MS = 32'(MS_NS / CLK_PERIOD_NS);
    localparam logic [1:0] ROUND_STAGES = 2'h3;
endpackage

// file: hw/ssg_setpoint_gen.sv
// Speed setpoint generator: potentiometer emulator, fixed setpoints, AHB-Lite registers
//
// Function
// - Raise or lower output while requested.
// - Ramp-up time configurable, ten seconds default.
// - Ramp-down time separate, ten seconds default.
// - Start value loaded at first switch-on.
// - Increase and decrease from selectable binary sources.
// - Five-bit configuration word, reset 00110.
// - Bit 0 retains output across switch-off.
// - Automatic mode ramps only with bit 1.
// - Manual mode always ramps.
// - Bit 2 adds initial rounding.
// - Bits 3 and 0 keep output over power loss.
// - Bit 4 updates regardless of pulse enable.
// - Output clamped between minimum and maximum.
// - Setting value from selectable source.
// - Main setpoint source 1050 is emulator.
// - Source 1024 is fixed setpoint selector.
// - Sixteen fixed setpoints, four select bits.
// - Direct mode sums the selected setpoints.
// - Binary mode picks one of sixteen.
// - Mode value one means direct selection.
`timescale 1ns/100ps
module ssg_setpoint_gen (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic [5:0] i_digital_in,
    input wire logic [15:0] i_fieldbus_bits,
    input wire logic [15:0] i_fieldbus_word,
    input wire logic i_pulse_enable,
    input wire logic i_power_fail,
    input wire logic i_nv_valid,
    input wire logic [15:0] i_nv_value,
    output logic o_nv_write,
    output ssg_pkg::ssg_speed_type o_nv_value,
    output ssg_pkg::ssg_speed_type o_emu_output,
    output ssg_pkg::ssg_speed_type o_main_setpoint,
    output ssg_pkg::ssg_speed_type o_additional_setpoint,
    output logic o_motor_on
);
    import ssg_pkg::*;

    logic [4:0] cfg_q;
    logic [15:0] up_time_q, down_time_q, ref_q, fix_mode_q;
    logic [15:0] main_src_q, add_src_q, set_src_q;
    ssg_speed_type start_q, max_q, min_q, emu_q, retained_q;
    logic [31:0] emu_src_q, fix_src_q;
    logic ret_valid_q, wr_pend_q, on_prev_q, acc_prev_q, pf_prev_q;
    logic [7:0] wr_addr_q;
    logic [31:0] acc_q;
    logic [1:0] stage_q;
    ssg_ramp_state_type state_q, state_d;
    logic inc_req, dec_req, auto_mode, on_cmd, set_accept;
    logic [3:0] fix_sel;
    logic up_req, dn_req, update_en, ramp_on, moving, jump, step;
    logic load_on, load_set;
    logic [15:0] time_ms, eff_ref, fix_rdata;
    logic [31:0] time_cyc, acc_sum, rd_mux;
    ssg_speed_type fixed_sp, on_value, set_value, start_lim, ret_lim;
    logic addr_ok, bus_we;

    // Picks one binary signal from constants, digital inputs or fieldbus bits
    function automatic logic pick_bit(input logic [7:0] code, input logic [5:0] di,
                                      input logic [15:0] fb);
        logic r;
        r = 1'b0;
        if (code == BSRC_ONE) begin
            r = 1'b1;
        end else if (code[7:4] == BSRC_DI && code[3:0] < 4'h6) begin
            r = di[code[2:0]];
        end else if (code[7:4] == BSRC_FB) begin
            r = fb[code[3:0]];
        end
        return r;
    endfunction

    // Clamp into the window; maximum checked first
    function automatic ssg_speed_type clamp(input logic signed [16:0] v,
                                            input ssg_speed_type lo,
                                            input ssg_speed_type hi);
        ssg_speed_type r;
        r = v[15:0];
        if (v > 17'(hi)) begin
            r = hi;
        end else if (v < 17'(lo)) begin
            r = lo;
        end
        return r;
    endfunction

    // Address phase decode; only whole-word transfers write
    assign addr_ok = i_hsel && i_hready && i_htrans[1];
    assign bus_we = wr_pend_q && wr_addr_q[7:6] == 2'h0;

    // AHB-Lite data-phase bookkeeping; zero wait states, always OKAY
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            o_hrdata <= 32'h0000_0000;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
            wr_pend_q <= addr_ok && i_hwrite && i_hsize == 3'h2 && i_haddr[31:8] == 24'h0;
            if (addr_ok) begin
                wr_addr_q <= {i_haddr[7:2], 2'h0};
            end
            if (addr_ok && !i_hwrite) begin
                o_hrdata <= rd_mux;
            end
        end
    end

    // Read mux; unmapped words read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (i_haddr[31:8] == 24'h0 && i_haddr[7:6] == FIX_PAGE) begin
            rd_mux = {16'h0000, fix_rdata};
        end else if (i_haddr[31:8] == 24'h0) begin
            unique case ({i_haddr[7:2], 2'h0})
                OFS_CONFIG: rd_mux = {27'h0, cfg_q};
                OFS_UP_TIME: rd_mux = {16'h0, up_time_q};
                OFS_DOWN_TIME: rd_mux = {16'h0, down_time_q};
                OFS_START: rd_mux = {16'h0, start_q};
                OFS_MAX: rd_mux = {16'h0, max_q};
                OFS_MIN: rd_mux = {16'h0, min_q};
                OFS_REF_SPEED: rd_mux = {16'h0, ref_q};
                OFS_FIX_MODE: rd_mux = {16'h0, fix_mode_q};
                OFS_EMU_SRC: rd_mux = emu_src_q;
                OFS_FIX_SRC: rd_mux = fix_src_q;
                OFS_MAIN_SRC: rd_mux = {16'h0, main_src_q};
                OFS_ADD_SRC: rd_mux = {16'h0, add_src_q};
                OFS_SET_SRC: rd_mux = {16'h0, set_src_q};
                OFS_STATUS: rd_mux = {14'h0, ret_valid_q, o_motor_on, emu_q};
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // Software registers
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            cfg_q <= CONFIG_RST;
            up_time_q <= RAMP_TIME_RST;
            down_time_q <= RAMP_TIME_RST;
            start_q <= SPEED_RST;
            max_q <= SPEED_RST;
            min_q <= SPEED_RST;
            ref_q <= REF_SPEED_RST;
            fix_mode_q <= FIX_MODE_RST;
            emu_src_q <= SRC_RST;
            fix_src_q <= SRC_RST;
            main_src_q <= 16'h0000;
            add_src_q <= 16'h0000;
            set_src_q <= 16'h0000;
        end else if (bus_we) begin
            unique case (wr_addr_q)
                OFS_CONFIG: cfg_q <= i_hwdata[4:0];
                OFS_UP_TIME: up_time_q <= i_hwdata[15:0];
                OFS_DOWN_TIME: down_time_q <= i_hwdata[15:0];
                OFS_START: start_q <= i_hwdata[15:0];
                OFS_MAX: max_q <= i_hwdata[15:0];
                OFS_MIN: min_q <= i_hwdata[15:0];
                OFS_REF_SPEED: ref_q <= i_hwdata[15:0];
                OFS_FIX_MODE: fix_mode_q <= i_hwdata[15:0];
                OFS_EMU_SRC: emu_src_q <= i_hwdata;
                OFS_FIX_SRC: fix_src_q <= i_hwdata;
                OFS_MAIN_SRC: main_src_q <= i_hwdata[15:0];
                OFS_ADD_SRC: add_src_q <= i_hwdata[15:0];
                OFS_SET_SRC: set_src_q <= i_hwdata[15:0];
                default: ;
            endcase
        end
    end

    // binary signal routing, all default to constant zero
    always_comb begin
        inc_req = pick_bit(emu_src_q[7:0], i_digital_in, i_fieldbus_bits);
        dec_req = pick_bit(emu_src_q[15:8], i_digital_in, i_fieldbus_bits);
        auto_mode = pick_bit(emu_src_q[23:16], i_digital_in, i_fieldbus_bits);
        on_cmd = pick_bit(emu_src_q[31:24], i_digital_in, i_fieldbus_bits);
        set_accept = pick_bit(set_src_q[15:8], i_digital_in, i_fieldbus_bits);
    end

    // four selection bits for the fixed table
    for (genvar g = 0; g < 4; g++) begin : g_fix_sel
        assign fix_sel[g] = pick_bit(fix_src_q[8*g +: 8], i_digital_in, i_fieldbus_bits);
    end

    ssg_fixed_select u_fixed (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_we(wr_pend_q && wr_addr_q[7:6] == FIX_PAGE),
        .i_widx(wr_addr_q[5:2]),
        .i_wdata(i_hwdata[15:0]),
        .i_ridx(i_haddr[5:2]),
        .o_rdata(fix_rdata),
        .i_sel(fix_sel),
        .i_direct(fix_mode_q == FIX_MODE_DIRECT),
        .o_setpoint(fixed_sp)
    );

    // Edge detection of switch-on, setting accept and power failure
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            on_prev_q <= 1'b0;
            acc_prev_q <= 1'b0;
            pf_prev_q <= 1'b0;
        end else begin
            on_prev_q <= on_cmd;
            acc_prev_q <= set_accept;
            pf_prev_q <= i_power_fail;
        end
    end

    assign load_on = on_cmd && !on_prev_q;
    assign load_set = set_accept && !acc_prev_q;
    // setting value is the fieldbus word or zero
    assign set_value = set_src_q[0] ? i_fieldbus_word : 16'sh0000;

    // retained value wins over start value when enabled
    always_comb begin
        on_value = start_q;
        if (cfg_q[CFG_RETAIN] && ret_valid_q) begin
            on_value = retained_q;
        // after power loss the stored copy is restored
        end else if (cfg_q[CFG_RETAIN] && cfg_q[CFG_NV] && i_nv_valid) begin
            on_value = i_nv_value;
        end
    end

    // Request decode; both together hold the output
    assign up_req = inc_req && !dec_req;
    assign dn_req = dec_req && !inc_req;
    // pulse enable gates updates unless bit 4
    assign update_en = cfg_q[CFG_ALWAYS] || i_pulse_enable;
    // automatic mode ramps only with bit 1
    assign ramp_on = !auto_mode || cfg_q[CFG_AUTO_RAMP];
    assign time_ms = up_req ? up_time_q : down_time_q;
    assign moving = (up_req || dn_req) && update_en && ramp_on && time_ms != 16'h0;
    assign jump = (up_req || dn_req) && update_en && !moving;

    // rate of ref speed per configured time, one rpm per step
    always_comb begin
        time_cyc = {16'h0, time_ms} * CYC_PER_MS;
        eff_ref = ref_q >> stage_q;
        acc_sum = acc_q + {16'h0, eff_ref};
        step = moving && acc_sum >= time_cyc;
    end

    // Ramp direction state
    always_comb begin
        state_d = RAMP_IDLE;
        if (moving && up_req) begin
            state_d = RAMP_UP;
        end else if (moving) begin
            state_d = RAMP_DOWN;
        end
    end

    // Accumulator and rounding stage, restarted on each new ramp
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            state_q <= RAMP_IDLE;
            acc_q <= 32'h0;
            stage_q <= 2'h0;
        end else begin
            state_q <= state_d;
            if (state_d != state_q) begin
                acc_q <= 32'h0;
                // slow first steps allow tiny changes
                stage_q <= cfg_q[CFG_ROUND] ? ROUND_STAGES : 2'h0;
            end else if (step) begin
                acc_q <= acc_sum - time_cyc;
                if (stage_q != 2'h0) begin
                    stage_q <= stage_q - 2'h1;
                end
            end else if (moving) begin
                acc_q <= acc_sum;
            end
        end
    end

    assign start_lim = clamp(17'(on_value), min_q, max_q);
    assign ret_lim = clamp(17'(retained_q), min_q, max_q);

    // every path through the output is clamped except the downward jump, which loads min_q as it is
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            emu_q <= SPEED_RST;
        end else if (load_on) begin
            // switch-on loads start or kept value
            emu_q <= start_lim;
        end else if (load_set) begin
            emu_q <= clamp(17'(set_value), min_q, max_q);
        end else if (jump) begin
            emu_q <= up_req ? clamp(17'(max_q), min_q, max_q) : min_q;
        end else if (step) begin
            // one rpm per step while requested
            emu_q <= clamp(17'(emu_q) + (up_req ? 17'sh00001 : -17'sh00001), min_q, max_q);
        end else begin
            emu_q <= clamp(17'(emu_q), min_q, max_q);
        end
    end

    // keep output at switch-off; store copy on power loss
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            retained_q <= SPEED_RST;
            ret_valid_q <= 1'b0;
            o_nv_write <= 1'b0;
            o_nv_value <= SPEED_RST;
        end else begin
            if (!on_cmd && on_prev_q && cfg_q[CFG_RETAIN]) begin
                retained_q <= emu_q;
                ret_valid_q <= 1'b1;
            end
            o_nv_write <= i_power_fail && !pf_prev_q && cfg_q[CFG_RETAIN] && cfg_q[CFG_NV];
            if (i_power_fail && !pf_prev_q) begin
                o_nv_value <= emu_q;
            end
        end
    end

    // Setpoint routing by source code; other codes give zero
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_main_setpoint <= SPEED_RST;
            o_additional_setpoint <= SPEED_RST;
            o_emu_output <= SPEED_RST;
            o_motor_on <= 1'b0;
        end else begin
            o_emu_output <= emu_q;
            o_motor_on <= on_cmd;
            // fixed code on main and additional
            o_main_setpoint <= main_src_q == SRC_EMU ? emu_q :
                               main_src_q == SRC_FIXED ? fixed_sp : 16'sh0000;
            o_additional_setpoint <= add_src_q == SRC_EMU ? emu_q :
                                     add_src_q == SRC_FIXED ? fixed_sp : 16'sh0000;
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);

    property p_switch_on;
        load_on |=> emu_q == $past(start_lim);
    endproperty
    a_switch_on: assert property (p_switch_on) else $error("switch-on value wrong");

    property p_retain;
        load_on && cfg_q[CFG_RETAIN] && ret_valid_q |=> emu_q == $past(ret_lim);
    endproperty
    a_retain: assert property (p_retain) else $error("retained value not restored");

    property p_clamp;
        min_q <= max_q && $stable(min_q) && $stable(max_q) |-> emu_q <= max_q && emu_q >= min_q;
    endproperty
    a_clamp: assert property (p_clamp) else $error("output outside limits");

    property p_step_up;
        step && up_req && !load_on && !load_set && emu_q < max_q && emu_q >= min_q
            ##0 $stable(max_q) ##0 $stable(min_q) |=> emu_q == $past(emu_q) + 16'sh0001;
    endproperty
    a_step_up: assert property (p_step_up) else $error("ramp step not one rpm");

    property p_auto_jump;
        auto_mode && !cfg_q[CFG_AUTO_RAMP] && up_req && update_en && !load_on && !load_set
            && min_q <= max_q |=> emu_q == $past(max_q);
    endproperty
    a_auto_jump: assert property (p_auto_jump) else $error("auto mode did not jump");

    property p_manual_ramp;
        !auto_mode && (up_req || dn_req) && update_en && time_ms != 16'h0 |-> !jump;
    endproperty
    a_manual_ramp: assert property (p_manual_ramp) else $error("manual mode skipped ramp");

    property p_pulse_gate;
        !cfg_q[CFG_ALWAYS] && !i_pulse_enable && !load_on && !load_set && $stable(min_q)
            && $stable(max_q) && emu_q <= max_q && emu_q >= min_q |=> $stable(emu_q);
    endproperty
    a_pulse_gate: assert property (p_pulse_gate) else $error("update without pulses");

    property p_main_emu;
        main_src_q == SRC_EMU |=> o_main_setpoint == $past(emu_q);
    endproperty
    a_main_emu: assert property (p_main_emu) else $error("main not from emulator");

    property p_main_fixed;
        main_src_q == SRC_FIXED |=> o_main_setpoint == $past(fixed_sp);
    endproperty
    a_main_fixed: assert property (p_main_fixed) else $error("main not from fixed");

    property p_rate;
        step |-> acc_sum >= time_cyc && time_cyc != 32'h0;
    endproperty
    a_rate: assert property (p_rate) else $error("step before time elapsed");
endmodule

// file: testbench/ssg_ctrl_model.sv
// Controller model driving the binary sources and the setting word
`timescale 1ns/100ps
module ssg_ctrl_model (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic [5:0] i_di_cmd,
    input wire logic [15:0] i_fb_cmd,
    input wire logic i_pulse_cmd,
    output logic [5:0] o_digital_in,
    output logic [15:0] o_fieldbus_bits,
    output logic [15:0] o_fieldbus_word,
    output logic o_pulse_enable
);
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_digital_in <= 6'h00;
            o_fieldbus_bits <= 16'h0000;
            o_fieldbus_word <= 16'h0000;
            o_pulse_enable <= 1'b0;
        end else begin
            o_digital_in <= i_di_cmd;
            o_fieldbus_bits <= i_fb_cmd;
            o_fieldbus_word <= o_fieldbus_word + 16'h0001; // Never idle, so stale values show
            o_pulse_enable <= i_pulse_cmd;
        end
    end
endmodule

// file: testbench/tb_speed_setpoint_source_generator.sv
// Self-checking bench for the speed setpoint source generator
`timescale 1ns/100ps
module tb_speed_setpoint_source_generator;
    import ssg_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0, hwrite = 1'b0, pulse_cmd = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_obs;
    logic hrdy, hresp, nv_wr, motor_on;
    logic [5:0] di_cmd = 6'h00, di;
    logic [15:0] fb_cmd = 16'h0000, fb, fw, rnd;
    ssg_speed_type nv_val, emu, main_sp, add_sp;
    logic [1:0] kq[$];
    logic [31:0] vq[$];
    int err_total = 0, compares = 0;
    event res_ev;
    logic pe;
    always #25 clk = ~clk;
    ssg_ctrl_model i_ctrl (.i_clk_sys(clk), .i_reset(rst), .i_di_cmd(di_cmd),
        .i_fb_cmd(fb_cmd), .i_pulse_cmd(pulse_cmd), .o_digital_in(di),
        .o_fieldbus_bits(fb), .o_fieldbus_word(fw), .o_pulse_enable(pe));
    ssg_setpoint_gen i_dut (.i_clk_sys(clk), .i_reset(rst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
        .i_digital_in(di), .i_fieldbus_bits(fb), .i_fieldbus_word(fw), .i_pulse_enable(pe),
        .i_power_fail(1'b0), .i_nv_valid(1'b0), .i_nv_value(16'h0000), .o_nv_write(nv_wr),
        .o_nv_value(nv_val), .o_emu_output(emu), .o_main_setpoint(main_sp),
        .o_additional_setpoint(add_sp), .o_motor_on(motor_on));
    // Verdict and end of run, also reached by a timeout
    task automatic final_report();
        $display("Counts: compares=%0d errors=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic cmp_reg(input logic [31:0] a, input logic [31:0] e);
        compares++;
        if (a !== e) begin
            err_total++;
            $display("Error at %0t: read %h expected %h", $time, a, e);
        end
    endtask
    task automatic cmp_speed(input ssg_speed_type a, input ssg_speed_type e);
        compares++;
        if (a !== e) begin
            err_total++;
            $display("Error at %0t: speed %h expected %h", $time, a, e);
        end
    endtask
    // Bounded wait for hready, so a stuck slave cannot hang the run
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hrdy !== 1'b1 && n < 64);
        if (hrdy !== 1'b1) begin
            err_total++;
            final_report();
        end
    endtask
    // One single word transfer; address phase then data phase
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd_obs = hrdata;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        kq.push_back(2'h0);
        vq.push_back(e);
        bus(1'b0, a, 32'h0);
        -> res_ev;
    endtask
    // Outputs settle over a few pipeline stages, so poll them at the falling edge
    task automatic expect_out(input logic [1:0] k, input ssg_speed_type v);
        int n;
        ssg_speed_type a;
        n = 0;
        kq.push_back(k);
        vq.push_back({16'h0, v});
        do begin
            @(negedge clk);
            a = (k == 2'h1) ? main_sp : (k == 2'h2) ? add_sp : emu;
            n++;
        end while (a !== v && n < 200);
        -> res_ev;
    endtask
    task automatic set_di(input logic [5:0] v);
        @(posedge clk);
        di_cmd <= v;
    endtask
    // Result watcher: each result is paired with the oldest note
    initial begin
        logic [1:0] k;
        logic [31:0] v;
        forever begin
            @(res_ev);
            k = kq.pop_front();
            v = vq.pop_front();
            if (k == 2'h0) begin
                cmp_reg(rd_obs, v);
            end else begin
                cmp_speed((k == 2'h1) ? main_sp : (k == 2'h2) ? add_sp : emu, v[15:0]);
            end
        end
    end
    initial begin
        rnd = 16'($urandom(32'h686f));
        rnd = 16'($urandom());
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(32'h00, 32'h6);
        rd(32'h04, 32'd10000);
        rd(32'h08, 32'd10000);
        rd(32'h1c, 32'h1);
        rd(32'h38, 32'h0);
        $display("Test register reset values done");
        bus(1'b1, 32'h40, 32'd300);
        bus(1'b1, 32'h44, 32'd2000);
        bus(1'b1, 32'h24, 32'h0000_1110);
        bus(1'b1, 32'h28, 32'h400);
        bus(1'b1, 32'h2c, 32'h400);
        set_di(6'h01);
        expect_out(2'h1, 16'sd300);
        set_di(6'h03);
        expect_out(2'h2, 16'sd2300);
        set_di(6'h00);
        expect_out(2'h1, 16'sd0);
        bus(1'b1, 32'h1c, 32'h0);
        bus(1'b1, 32'h7c, {16'h0, rnd});
        bus(1'b1, 32'h24, 32'h2322_2120);
        fb_cmd <= 16'h000f;
        expect_out(2'h1, rnd);
        $display("Test fixed setpoints done");
        bus(1'b1, 32'h00, 32'h0);
        bus(1'b1, 32'h0c, 32'd100);
        bus(1'b1, 32'h10, 32'd1000);
        bus(1'b1, 32'h14, 32'h0000_fe0c);
        bus(1'b1, 32'h20, 32'h1401_1312);
        bus(1'b1, 32'h28, 32'h41a);
        pulse_cmd <= 1'b1;
        set_di(6'h10);
        expect_out(2'h3, 16'sd100);
        set_di(6'h14);
        expect_out(2'h1, 16'sd1000);
        set_di(6'h18);
        expect_out(2'h3, -16'sd500);
        set_di(6'h00);
        set_di(6'h10);
        expect_out(2'h3, 16'sd100);
        // Manual ramp of one rpm per cycle, then retain across switch-off
        bus(1'b1, 32'h18, 32'd20000);
        bus(1'b1, 32'h04, 32'd1);
        bus(1'b1, 32'h10, 32'd150);
        bus(1'b1, 32'h00, 32'h1);
        bus(1'b1, 32'h20, 32'h1400_1312);
        set_di(6'h14);
        expect_out(2'h3, 16'sd150);
        set_di(6'h00);
        set_di(6'h10);
        repeat (4) @(posedge clk);
        expect_out(2'h3, 16'sd150);
        rd(32'h34, 32'h0003_0096);
        $display("Test emulator done");
        final_report();
    end
endmodule
